//--- sbp_pkg.sv
// Constants, carriers and table contents for the basic parameter table store
package sbp_pkg;

    // Serial framing
    localparam logic [7:0] OPC_PARAM_READ = 8'h5A;
    localparam logic [5:0] CMD_LAST       = 6'h07;
    localparam logic [5:0] ADDR_LAST      = 6'h1F;
    localparam logic [5:0] DUMMY_LAST     = 6'h27;
    localparam logic [5:0] DATA_START     = 6'h28;
    localparam logic [2:0] BIT_FIRST      = 3'h0;

    // Table placement
    localparam logic [7:0] BPT_BASE       = 8'h80;
    localparam logic [7:0] BPT_LAST       = 8'h93;
    localparam logic [7:0] FILL_BYTE      = 8'hFF;

    // Table byte addresses
    localparam logic [7:0] A_ERASE_INFO   = 8'h80;
    localparam logic [7:0] A_ERASE_OPC    = 8'h81;
    localparam logic [7:0] A_READ_FLAGS   = 8'h82;
    localparam logic [7:0] A_DW1_TOP      = 8'h83;
    localparam logic [7:0] A_DENS_0       = 8'h84;
    localparam logic [7:0] A_DENS_1       = 8'h85;
    localparam logic [7:0] A_DENS_2       = 8'h86;
    localparam logic [7:0] A_DENS_3       = 8'h87;
    localparam logic [7:0] A_QIO_WAIT     = 8'h88;
    localparam logic [7:0] A_QIO_OPC      = 8'h89;
    localparam logic [7:0] A_QOR_WAIT     = 8'h8A;
    localparam logic [7:0] A_QOR_OPC      = 8'h8B;
    localparam logic [7:0] A_DOR_WAIT     = 8'h8C;
    localparam logic [7:0] A_DOR_OPC      = 8'h8D;
    localparam logic [7:0] A_DIO_WAIT     = 8'h8E;
    localparam logic [7:0] A_DIO_OPC      = 8'h8F;
    localparam logic [7:0] A_ALLMODE      = 8'h90;
    localparam logic [7:0] A_RSV_1        = 8'h91;
    localparam logic [7:0] A_RSV_3        = 8'h93;

    // Fields of the first table byte
    localparam logic [2:0] B80_UNUSED     = 3'h7;
    localparam logic [1:0] SR_VOLATILE    = 2'h0;
    localparam logic       PROG_BUF_BIG   = 1'h1;
    localparam logic [1:0] ERASE_GRAN     = 2'h1;
    localparam logic [7:0] B_ERASE_INFO   = {B80_UNUSED, SR_VOLATILE, PROG_BUF_BIG, ERASE_GRAN};

    localparam logic [7:0] B_ERASE_OPC    = 8'h20;
    localparam logic [7:0] B_READ_FLAGS   = 8'hF1;
    localparam logic       FAST_READ_BIT  = 1'h1;
    localparam logic [7:0] B_DW1_TOP      = 8'hFF;
    localparam logic [31:0] DENSITY_BITS  = 32'h07FF_FFFF;

    // Mode, dummy cycle and opcode fields
    localparam logic [2:0] QIO_MODE       = 3'h2;
    localparam logic [4:0] QIO_DUMMY      = 5'h04;
    localparam logic [2:0] QOR_MODE       = 3'h0;
    localparam logic [4:0] QOR_DUMMY      = 5'h08;
    localparam logic [2:0] DOR_MODE       = 3'h0;
    localparam logic [4:0] DOR_DUMMY      = 5'h08;
    localparam logic [2:0] DIO_MODE       = 3'h2;
    localparam logic [4:0] DIO_DUMMY      = 5'h00;
    localparam logic [7:0] B_QIO_OPC      = 8'hEB;
    localparam logic [7:0] B_QOR_OPC      = 8'h6B;
    localparam logic [7:0] B_DOR_OPC      = 8'h3B;
    localparam logic [7:0] B_DIO_OPC      = 8'hBB;

    // All-line protocol byte
    localparam logic [2:0] RSV_HI         = 3'h7;
    localparam logic       ALL_QUAD_OK    = 1'h0;
    localparam logic [2:0] RSV_MID        = 3'h7;
    localparam logic       ALL_DUAL_OK    = 1'h0;
    localparam logic [7:0] B_ALLMODE      = {RSV_HI, ALL_QUAD_OK, RSV_MID, ALL_DUAL_OK};
    localparam logic [7:0] B_RESERVED     = 8'hFF;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } sbp_pins_t;

    typedef enum logic [2:0] {
        PH_CMD,
        PH_ADDR,
        PH_DUMMY,
        PH_DATA,
        PH_IGNORE
    } sbp_phase_t;

endpackage

//--- sbp_rom.sv
// Basic flash parameter table store with its serial read front end
`timescale 1ns/1ps

module sbp_rom
    import sbp_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire sbp_pins_t  pins,
    output logic            so,
    output logic            so_oe,
    output logic            table_hit,
    output logic [7:0]      cur_addr
);

    // Table decode, shared by the shifter and the checks
    function automatic logic [7:0] sbp_lookup(input logic [7:0] a);
        logic [7:0] b;
        b = FILL_BYTE;
        case (a)
            A_ERASE_INFO: b = B_ERASE_INFO;
            A_ERASE_OPC:  b = B_ERASE_OPC;
            A_READ_FLAGS: b = {B_READ_FLAGS[7:1], FAST_READ_BIT};
            A_DW1_TOP:    b = B_DW1_TOP;
            A_DENS_0:     b = DENSITY_BITS[7:0];
            A_DENS_1:     b = DENSITY_BITS[15:8];
            A_DENS_2:     b = DENSITY_BITS[23:16];
            A_DENS_3:     b = DENSITY_BITS[31:24];
            A_QIO_WAIT:   b = {QIO_MODE, QIO_DUMMY};
            A_QIO_OPC:    b = B_QIO_OPC;
            A_QOR_WAIT:   b = {QOR_MODE, QOR_DUMMY};
            A_QOR_OPC:    b = B_QOR_OPC;
            A_DOR_WAIT:   b = {DOR_MODE, DOR_DUMMY};
            A_DOR_OPC:    b = B_DOR_OPC;
            A_DIO_WAIT:   b = {DIO_MODE, DIO_DUMMY};
            A_DIO_OPC:    b = B_DIO_OPC;
            A_ALLMODE:    b = B_ALLMODE;
            default:      b = B_RESERVED;
        endcase
        return b;
    endfunction

    function automatic logic in_table(input logic [7:0] a);
        return (a >= BPT_BASE) && (a <= BPT_LAST);
    endfunction

    // Pin synchronisers
    sbp_pins_t  pins_m_q;
    sbp_pins_t  pins_s_q;
    logic       sclk_d1_q;
    logic       rise;
    logic       fall;
    logic       cs_act;
    logic       mosi_s;

    // Serial engine state
    sbp_phase_t phase_q;
    logic [5:0] cnt_q;
    logic [7:0] opc_q;
    logic [7:0] addr_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] cur_byte_q;
    logic       so_q;
    logic       so_oe_q;
    logic       hit_q;
    logic       load;
    logic       sh_msb;
    logic [7:0] next_byte;

    always_ff @(posedge clock) begin
        if (rst) begin
            pins_m_q  <= '{sclk: 1'h0, cs_n: 1'h1, mosi: 1'h0};
            pins_s_q  <= '{sclk: 1'h0, cs_n: 1'h1, mosi: 1'h0};
            sclk_d1_q <= 1'h0;
        end else begin
            pins_m_q  <= pins;
            pins_s_q  <= pins_m_q;
            sclk_d1_q <= pins_s_q.sclk;
        end
    end

    assign rise      = pins_s_q.sclk & ~sclk_d1_q;
    assign fall      = ~pins_s_q.sclk & sclk_d1_q;
    assign cs_act    = ~pins_s_q.cs_n;
    assign mosi_s    = pins_s_q.mosi;
    assign load      = fall && (phase_q == PH_DATA) && (bit_q == BIT_FIRST);
    assign sh_msb    = sh_q[7];
    assign next_byte = sbp_lookup(addr_q);

    // Phase sequencing on rising serial clock
    always_ff @(posedge clock) begin
        if (rst || !cs_act) begin
            phase_q <= PH_CMD;
        end else if (rise) begin
            case (phase_q)
                PH_CMD: begin
                    if (cnt_q == CMD_LAST) begin
                        if ({opc_q[6:0], mosi_s} == OPC_PARAM_READ) begin
                            phase_q <= PH_ADDR;
                        end else begin
                            phase_q <= PH_IGNORE;
                        end
                    end
                end
                PH_ADDR: begin
                    if (cnt_q == ADDR_LAST) begin
                        phase_q <= PH_DUMMY;
                    end
                end
                PH_DUMMY: begin
                    if (cnt_q == DUMMY_LAST) begin
                        phase_q <= PH_DATA;
                    end
                end
                PH_DATA:   phase_q <= PH_DATA;
                PH_IGNORE: phase_q <= PH_IGNORE;
                default:   phase_q <= PH_CMD;
            endcase
        end
    end

    // Rising edge count up to the first data clock
    always_ff @(posedge clock) begin
        if (rst || !cs_act) begin
            cnt_q <= '0;
        end else if (rise && (phase_q inside {PH_CMD, PH_ADDR, PH_DUMMY})) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // Opcode capture
    always_ff @(posedge clock) begin
        if (rst || !cs_act) begin
            opc_q <= '0;
        end else if (rise && (phase_q == PH_CMD)) begin
            opc_q <= {opc_q[6:0], mosi_s};
        end
    end

    // Address: upper bits shift out, low byte stays and then walks
    always_ff @(posedge clock) begin
        if (rst) begin
            addr_q <= '0;
        end else if (rise && (phase_q == PH_ADDR)) begin
            addr_q <= {addr_q[6:0], mosi_s};
        end else if (load) begin
            addr_q <= addr_q + 8'h01;
        end
    end

    // Output shifter, MSB first on falling edges
    always_ff @(posedge clock) begin
        if (rst || !cs_act) begin
            bit_q <= BIT_FIRST;
            sh_q  <= '0;
            so_q  <= 1'h0;
        end else if (fall && (phase_q == PH_DATA)) begin
            bit_q <= bit_q + 3'h1;
            if (load) begin
                so_q <= next_byte[7];
                sh_q <= {next_byte[6:0], 1'h0};
            end else begin
                so_q <= sh_q[7];
                sh_q <= {sh_q[6:0], 1'h0};
            end
        end
    end

    // Byte in flight and table hit flag
    always_ff @(posedge clock) begin
        if (rst) begin
            cur_byte_q <= FILL_BYTE;
            hit_q      <= 1'h0;
        end else if (load) begin
            cur_byte_q <= next_byte;
            hit_q      <= in_table(addr_q);
        end
    end

    // Output enable from first data edge until chip select rises
    always_ff @(posedge clock) begin
        if (rst || !cs_act) begin
            so_oe_q <= 1'h0;
        end else if (fall && (phase_q == PH_DATA)) begin
            so_oe_q <= 1'h1;
        end
    end

    assign so        = so_q;
    assign so_oe     = so_oe_q;
    assign table_hit = hit_q;
    assign cur_addr  = addr_q;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_load;
        fall && (phase_q == PH_DATA) && (bit_q == BIT_FIRST);
    endsequence

    sequence s_bad_opc;
        rise && (phase_q == PH_CMD) && (cnt_q == CMD_LAST)
            && ({opc_q[6:0], mosi_s} != OPC_PARAM_READ);
    endsequence

    a_opcode_gate: assert property (
        s_bad_opc |=> (phase_q == PH_IGNORE) && !so_oe_q)
        else $error("wrong opcode not ignored");

    a_addr_low: assert property (
        (rise && (phase_q == PH_ADDR)) |=> (addr_q[0] == $past(mosi_s)))
        else $error("address bit not captured");

    a_data_start: assert property (
        (phase_q == PH_DATA) |-> (cnt_q == DATA_START))
        else $error("data phase before clock 40");

    a_msb_first: assert property (
        s_load |=> (so_q == cur_byte_q[7]) && so_oe_q)
        else $error("first data bit not byte msb");

    a_shift_next: assert property (
        (fall && (phase_q == PH_DATA) && (bit_q != BIT_FIRST) && cs_act)
            |=> (so_q == $past(sh_msb)))
        else $error("data bit out of order");

    a_byte_walk: assert property (
        s_load |=> (addr_q == 8'($past(addr_q) + 8'h01)))
        else $error("address did not advance");

    a_first_byte: assert property (
        (s_load and (addr_q == BPT_BASE)) |=> (cur_byte_q == 8'hE5) && hit_q)
        else $error("table start byte wrong");

    a_erase_fields: assert property (
        (s_load and (addr_q == A_ERASE_INFO)) |=>
            (cur_byte_q[1:0] == ERASE_GRAN) && cur_byte_q[2]
            && (cur_byte_q[4:3] == SR_VOLATILE) && (cur_byte_q[7:5] == B80_UNUSED))
        else $error("erase info fields wrong");

    a_density: assert property (
        (s_load and (addr_q == A_DENS_3)) |=> (cur_byte_q == DENSITY_BITS[31:24]))
        else $error("density top byte wrong");

    a_reserved_tail: assert property (
        (s_load and (addr_q >= A_RSV_1) && (addr_q <= A_RSV_3))
            |=> (cur_byte_q == B_RESERVED))
        else $error("reserved byte not ones");

    a_cs_release: assert property (
        !cs_act |=> !so_oe_q && (phase_q == PH_CMD) && (cnt_q == 6'h00))
        else $error("frame state kept past chip select");

    a_table_fixed: assert property (
        s_load |=> (cur_byte_q == sbp_lookup($past(addr_q))))
        else $error("table content changed");

    a_hit_range: assert property (
        s_load |=> (hit_q == in_table($past(addr_q))))
        else $error("table hit flag wrong");

    a_all_line: assert property (
        (s_load and (addr_q == A_ALLMODE)) |=>
            (cur_byte_q[4] == ALL_QUAD_OK) && (cur_byte_q[0] == ALL_DUAL_OK))
        else $error("all-line protocol bits wrong");

endmodule

//--- sbp_host.sv
// SPI host model issuing parameter reads to the table store
`timescale 1ns/1ps

module sbp_host
    import sbp_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  so,
    input  wire logic  so_oe,
    output sbp_pins_t  pins
);
    logic [7:0] rx [0:31];
    logic       oe_seen;

    initial begin
        pins = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
        oe_seen = 1'b0;
    end

    // One frame: opcode, three address bytes, dummy byte, n bytes back
    task automatic frame(input logic [7:0] op, input logic [7:0] a, input int n);
        logic [39:0] hdr;
        hdr = {op, 16'h0000, a, 8'h00};
        oe_seen = 1'b0;
        pins.cs_n <= 1'b0;
        repeat (3) @(negedge clock);
        for (int i = 0; i < 40 + 8 * n; i++) begin
            pins.mosi <= (i < 40) ? hdr[39 - i] : ~pins.mosi;
            repeat (6) @(negedge clock);
            if (i >= 40) rx[(i - 40) / 8][7 - (i % 8)] = so;
            if (so_oe === 1'b1) oe_seen = 1'b1;
            pins.sclk <= 1'b1;
            repeat (6) @(negedge clock);
            pins.sclk <= 1'b0;
        end
        repeat (6) @(negedge clock);
        pins.cs_n <= 1'b1;
        pins.mosi <= ~pins.mosi;
        repeat (6) @(negedge clock);
    endtask
endmodule

//--- tb.sv
// Self-checking bench for the basic parameter table store
`timescale 1ns/1ps

module tb;
    import sbp_pkg::*;
    logic       clock;
    logic       rst;
    sbp_pins_t  pins;
    logic       so;
    logic       so_oe;
    logic       table_hit;
    logic [7:0] cur_addr;
    int         failures;
    int         samples_checked;
    logic [7:0] lfsr_q;

    sbp_rom i_dut (.clock(clock), .rst(rst), .pins(pins), .so(so), .so_oe(so_oe),
                   .table_hit(table_hit), .cur_addr(cur_addr));
    sbp_host i_host (.clock(clock), .so(so), .so_oe(so_oe), .pins(pins));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // Table image at each byte address
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        case (a)
            8'h80: return 8'hE5;
            8'h81: return 8'h20;
            8'h82: return 8'hF1;
            8'h83: return 8'hFF;
            8'h87: return 8'h07;
            8'h88: return 8'h44;
            8'h89: return 8'hEB;
            8'h8A: return 8'h08;
            8'h8B: return 8'h6B;
            8'h8C: return 8'h08;
            8'h8D: return 8'h3B;
            8'h8E: return 8'h40;
            8'h8F: return 8'hBB;
            8'h90: return 8'hEE;
            default: return 8'hFF;
        endcase
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One parameter read and its byte, address and hit comparisons
    task automatic read_check(input logic [7:0] a, input int n);
        logic [7:0] last;
        logic       hit;
        i_host.frame(8'h5A, a, n);
        for (int k = 0; k < n; k++) begin
            check("table byte", exp_byte(a + k[7:0]), i_host.rx[k]);
        end
        last = a + n[7:0];
        hit = (last >= 8'h80) && (last <= 8'h93);
        check("next address", last + 8'h01, cur_addr);
        check("table hit", {7'h00, hit}, {7'h00, table_hit});
        check("output enable idle", 8'h00, {7'h00, so_oe});
        $display("test read at %h length %0d done", a, n);
    endtask

    initial begin
        failures = 0;
        samples_checked = 0;
        lfsr_q = 8'h49;
        rst = 1'b1;
        repeat (20) @(negedge clock);
        rst <= 1'b0;
        repeat (3) @(negedge clock);
        check("reset address", 8'h00, cur_addr);
        read_check(8'h7F, 22);
        i_host.frame(8'h05, 8'h80, 2);
        check("enable on other opcode", 8'h00, {7'h00, i_host.oe_seen});
        $display("test other opcode done");
        for (int r = 0; r < 8; r++) begin
            lfsr_q = lfsr_next(lfsr_q);
            read_check(8'h78 + {3'h0, lfsr_q[4:0]}, 1 + lfsr_q[7:6]);
        end
        read_check(8'hFE, 3);
        read_check(8'h7F, 22);
        close_out();
    end

    initial begin
        repeat (40000) @(posedge clock);
        failures++;
        close_out();
    end
endmodule
